// ### core/rsr_pkg.sv
package rsr_pkg;

  // ===========================================================================
  // register map
  localparam int RSR_ADDR_W = 7;
  localparam logic [6:0] RSR_OFS_SIGNAL_STRENGTH = 7'h42;
  localparam logic [6:0] RSR_OFS_AVG_FREQ = 7'h43;
  localparam logic [6:0] RSR_OFS_INST_FREQ = 7'h44;
  localparam logic [6:0] RSR_OFS_CAL_PUMP = 7'h45;
  localparam logic [6:0] RSR_OFS_REV_OSC = 7'h46;
  localparam logic [6:0] RSR_OFS_OSC_CAL = 7'h47;
  localparam logic [6:0] RSR_OFS_CONV = 7'h48;
  localparam logic [6:0] RSR_OFS_FILT_I = 7'h49;
  localparam logic [6:0] RSR_OFS_FILT_Q = 7'h4a;
  localparam logic [6:0] RSR_OFS_GAIN_OFS = 7'h4b;

  // ===========================================================================
  // reset and fill values
  localparam logic [7:0] RSR_RDATA_RST = 8'h00;
  localparam logic [7:0] RSR_UNMAPPED_VAL = 8'h00;
  // revision code value is arbitrary
  localparam logic [2:0] RSR_REV_DEFAULT = 3'h5;

  // ===========================================================================
  // live status carried from the radio core
  typedef struct packed {
    logic [6:0] signal_strength;
    logic [7:0] avg_freq_offset;
    logic [7:0] inst_freq_offset;
    logic [3:0] cal_dac_value;
    logic [3:0] charge_pump_current_value;
    logic [4:0] oscillator_array_value;
    logic freq_comparator;
    logic oscillator_cal_comparator;
    logic [5:0] oscillator_cal_current;
    logic [1:0] conv_mixer_in;
    logic [2:0] conv_i_out;
    logic [2:0] conv_q_out;
    logic [7:0] filter_i_upper;
    logic [7:0] filter_q_upper;
    logic [4:0] gain_offset;
  } rsr_status_t;

endpackage

// ### core/rsr_read_mux.sv
`timescale 1ns/1ps
module rsr_read_mux
  import rsr_pkg::*;
(
  input wire logic [6:0] addr,
  input wire rsr_status_t st,
  input wire logic [2:0] rev_code,
  output logic [7:0] data,
  output logic hit
);

  // ===========================================================================
  // word assembly
  wire [7:0] w_sig = {1'b0, st.signal_strength};
  wire [7:0] w_cal = {st.cal_dac_value, st.charge_pump_current_value};
  wire [7:0] w_rev = {rev_code, st.oscillator_array_value};
  wire [7:0] w_osc = {st.freq_comparator, st.oscillator_cal_comparator, st.oscillator_cal_current};
  wire [7:0] w_conv = {st.conv_mixer_in, st.conv_i_out, st.conv_q_out};
  wire [7:0] w_gain = {3'h0, st.gain_offset};

  always_comb begin
    hit = 1'b1;
    case (addr)
      RSR_OFS_SIGNAL_STRENGTH: data = w_sig;
      RSR_OFS_AVG_FREQ: data = st.avg_freq_offset;
      RSR_OFS_INST_FREQ: data = st.inst_freq_offset;
      RSR_OFS_CAL_PUMP: data = w_cal;
      RSR_OFS_REV_OSC: data = w_rev;
      RSR_OFS_OSC_CAL: data = w_osc;
      RSR_OFS_CONV: data = w_conv;
      RSR_OFS_FILT_I: data = st.filter_i_upper;
      RSR_OFS_FILT_Q: data = st.filter_q_upper;
      RSR_OFS_GAIN_OFS: data = w_gain;
      default: begin
        data = RSR_UNMAPPED_VAL;
        hit = 1'b0;
      end
    endcase
  end

endmodule // rsr_read_mux

// ### core/rsr_status_bank.sv
`timescale 1ns/1ps
// Function
// - the status registers sit one byte each at 42h through 4Bh, starting with signal strength at 42h.
// - signal strength is a 7-bit value in bits 6..0 in 1.5 dB steps, with bit 7 reading 0.
// - 43h holds the averaged frequency offset as a signed byte equal to the demodulator decision level.
// - the averaged offset scales as symbol rate times value over 16.
// - 44h holds the instantaneous frequency offset as a signed byte scaled as symbol rate times value over 8.
// - 45h returns the calibration DAC value in bits 7..4 and charge-pump current in bits 3..0.
// - 46h returns the revision code in bits 7..5 and the oscillator array value in bits 4..0.
// - 47h returns the frequency comparator in bit 7 and the oscillator calibration comparator in bit 6.
// - 47h bits 5..0 return the applied oscillator calibration current.
// - 48h returns mixer input in bits 7..6, I converter output in 5..3 and Q output in 2..0.
// - 49h and 4Ah return the upper bytes of the channel filter I and Q outputs.
// - 4Bh returns zeros in bits 7..5 and the amplifier gain offset in bits 4..0.
module rsr_status_bank
  import rsr_pkg::*;
#(
  parameter logic [2:0] REV_CODE = RSR_REV_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire rsr_status_t status_in
);

  // ===========================================================================
  // decode
  wire [7:0] mux_data;
  wire mux_hit;

  rsr_read_mux u_mux (
    .addr(reg_addr),
    .st(status_in),
    .rev_code(REV_CODE),
    .data(mux_data),
    .hit(mux_hit)
  );

  // writes and their data are dropped on purpose
  wire unused_wr = reg_wr ^ (^reg_wdata);

  // ===========================================================================
  // read data register, valid the cycle after the read strobe
  logic [7:0] rdata_next;
  logic hit_next;
  assign rdata_next = reg_rd ? mux_data : RSR_RDATA_RST;
  assign hit_next = reg_rd & mux_hit;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= RSR_RDATA_RST;
      reg_hit <= 1'b0;
    end else begin
      reg_rdata <= rdata_next;
      reg_hit <= hit_next;
    end
  end

  // ===========================================================================
  // checks
  AST_RD_DATA: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd |=> reg_rdata == $past(mux_data)) else $error("read data mismatch");
  AST_SIG_MSB: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_SIGNAL_STRENGTH |=> reg_rdata[7] == 1'b0 && reg_hit)
    else $error("signal strength msb set");
  AST_AVG: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_AVG_FREQ |=> reg_rdata == $past(status_in.avg_freq_offset))
    else $error("avg offset wrong");
  AST_INST: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_INST_FREQ |=> reg_rdata == $past(status_in.inst_freq_offset))
    else $error("inst offset wrong");
  AST_REV: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_REV_OSC |=> reg_rdata[7:5] == REV_CODE)
    else $error("revision wrong");
  AST_GAIN: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_GAIN_OFS |=> reg_rdata[7:5] == 3'h0)
    else $error("gain offset high bits set");
  AST_FILT_Q: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_FILT_Q |=> reg_rdata == $past(status_in.filter_q_upper))
    else $error("filter q wrong");
  AST_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == RSR_RDATA_RST && !reg_hit) else $error("data without read");
  AST_OSC: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_OSC_CAL |=> reg_rdata[5:0] == $past(status_in.oscillator_cal_current))
    else $error("osc cal wrong");
  AST_SIG: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_SIGNAL_STRENGTH |=> reg_rdata[6:0] == $past(status_in.signal_strength))
    else $error("signal strength wrong");
  AST_CAL: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_CAL_PUMP |=>
    reg_rdata == {$past(status_in.cal_dac_value), $past(status_in.charge_pump_current_value)})
    else $error("cal pump status wrong");
  AST_OSC_CMP: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_OSC_CAL |=>
    reg_rdata[7:6] == {$past(status_in.freq_comparator), $past(status_in.oscillator_cal_comparator)})
    else $error("comparator bits wrong");
  AST_CONV: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_CONV |=>
    reg_rdata == {$past(status_in.conv_mixer_in), $past(status_in.conv_i_out), $past(status_in.conv_q_out)})
    else $error("converter sample wrong");
  AST_FILT_I: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == RSR_OFS_FILT_I |=> reg_rdata == $past(status_in.filter_i_upper))
    else $error("filter i wrong");
  AST_MISS: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && !mux_hit |=> reg_rdata == RSR_UNMAPPED_VAL && !reg_hit)
    else $error("unmapped read returned data");
  AST_HIT: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && mux_hit |=> reg_hit)
    else $error("mapped read without hit");
  AST_WR_IGN: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_wr && !reg_rd |=> reg_rdata == RSR_RDATA_RST && !reg_hit)
    else $error("write had an effect");
  COV_RD: cover property (@(posedge core_clk) reg_rd && mux_hit);
  COV_B2B: cover property (@(posedge core_clk) reg_rd ##1 reg_rd);
  COV_MISS: cover property (@(posedge core_clk) reg_rd && !mux_hit);
  COV_WR: cover property (@(posedge core_clk) reg_wr ##1 reg_rd);

endmodule // rsr_status_bank

// ### test/rsr_host_model.sv
`timescale 1ns/1ps
// ============================================================
// host bus master
module rsr_host_model (
  input wire logic core_clk,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle access; released address and data lines show the inverse, not the last value; both strobes return to 0
  // gain correction of the strength reading is left to host software
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge core_clk);
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
endmodule // rsr_host_model

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rsr_pkg::*;
  // arbitrary revision code
  localparam logic [2:0] REV = 3'h3;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_hit;
  rsr_status_t st = '0;
  logic [79:0] pat = {10{8'h96}};
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  rsr_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  rsr_status_bank #(.REV_CODE(REV)) dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .status_in(st));
  function automatic logic [7:0] expv(logic [6:0] a);
    case (a)
      7'h42: return {1'b0, st.signal_strength};
      7'h43: return st.avg_freq_offset;
      7'h44: return st.inst_freq_offset;
      7'h45: return {st.cal_dac_value, st.charge_pump_current_value};
      7'h46: return {REV, st.oscillator_array_value};
      7'h47: return {st.freq_comparator, st.oscillator_cal_comparator, st.oscillator_cal_current};
      7'h48: return {st.conv_mixer_in, st.conv_i_out, st.conv_q_out};
      7'h49: return st.filter_i_upper;
      7'h4a: return st.filter_q_upper;
      7'h4b: return {3'h0, st.gain_offset};
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdchk(logic [6:0] a);
    logic [7:0] e;
    host_u.acc(1'b0, a, 8'h00);
    #1;
    e = expv(a);
    chk("rdata", reg_rdata, e);
    chk("hit", {7'h00, reg_hit}, {7'h00, a >= 7'h42 && a <= 7'h4b});
    @(posedge core_clk);
    #1;
    chk("idle rdata", reg_rdata, 8'h00);
    chk("idle hit", {7'h00, reg_hit}, 8'h00);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("reset rdata", reg_rdata, 8'h00);
    for (int p = 0; p < 3; p++) begin
      @(posedge core_clk);
      st <= pat[72:0] ^ {73{p[0]}} | {73{p[1]}};
      for (int a = 'h41; a <= 'h4c; a++) rdchk(7'(a));
    end
    host_u.acc(1'b1, RSR_OFS_SIGNAL_STRENGTH, 8'h00);
    host_u.acc(1'b1, RSR_OFS_GAIN_OFS, 8'h00);
    rdchk(RSR_OFS_SIGNAL_STRENGTH);
    rdchk(RSR_OFS_GAIN_OFS);
    rdchk(7'h7f);
    rdchk(7'h00);
    tally_and_finish();
  end
endmodule // testbench
